// ---- logic/epl_defs.vh ----
// constants for the program memory access and lock block
`ifndef EPL_DEFS_VH
`define EPL_DEFS_VH

`define EPL_CODE_AW 13
`define EPL_CODE_DEPTH 8192
`define EPL_ENC_AW 6
`define EPL_ENC_DEPTH 64
`define EPL_SIG_DEPTH 4
`define EPL_ERASED 8'hff

`define EPL_OFF_CTRL 12'h000
`define EPL_OFF_ADDR 12'h004
`define EPL_OFF_DATA 12'h008
`define EPL_OFF_STAT 12'h00c

`define EPL_CTRL_EXT 0
`define EPL_CTRL_PROG_EN 1
`define EPL_CTRL_RESET 2'b10

`define EPL_SEL_PROG_CODE 5'b01111
`define EPL_SEL_PROG_ENC 5'b01101
`define EPL_SEL_LOCK1 5'b11111
`define EPL_SEL_LOCK2 5'b11100
`define EPL_SEL_LOCK3 5'b10110
`define EPL_SEL_VER_MASK 5'b10111
`define EPL_SEL_VERIFY 5'b00011
`define EPL_SEL_SIGN 5'b00000

`define EPL_MODE_IDLE 3'd0
`define EPL_MODE_PCODE 3'd1
`define EPL_MODE_PENC 3'd2
`define EPL_MODE_PLOCK 3'd3
`define EPL_MODE_VERIFY 3'd4
`define EPL_MODE_SIGN 3'd5

`define EPL_HTRANS_NONSEQ 2'b10
`define EPL_HRESP_OKAY 1'b0

`endif

// ---- logic/epl_core.v ----
// program memory with parallel programming, verify, encryption and locks
`timescale 1ns/1ps
`default_nettype none
`include "epl_defs.vh"

// Contract
// - 8 KB code array, 64-byte encryption array, 4-byte fixed signature
// - encryption bytes read as FF until written
// - verify output is code XNOR encryption byte at address low 6 bits
// - unprogrammed encryption byte leaves verify output equal to code byte
// - verifying an FF code byte yields the encryption byte
// - level 1: no protection, verify still encrypted, external reads plain
// - level 2: no external code reads, pin latched, no code or encryption programming
// - level 3: level 2 plus verify disabled
// - level 4: level 3 plus external execution disabled
// - address on port 1 and port 2 bits 0-4, data on port 0
module epl_core #(
    parameter [31:0] SIG_WORD = 32'h5a5a_a5a5
) (
    input wire clock,
    input wire arst_n,
    input wire reset_pin,
    input wire program_store_strobe_n,
    input wire latch_or_prog_strobe,
    input wire ext_access_or_prog_voltage,
    input wire prog_voltage_present,
    input wire external_access_n,
    input wire select_a,
    input wire select_b,
    input wire select_c,
    input wire select_d,
    input wire select_e,
    input wire [7:0] port1_in,
    input wire [4:0] port2_in,
    input wire [7:0] port0_in,
    output wire [7:0] port0_out,
    output wire port0_oe,
    output wire ext_exec_enable,
    output wire ext_access_effective_n,
    output wire [1:0] security_level,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp
);
    // pin bundle, msb first: reset, store strobe, program strobe, access
    // level, voltage, selects a-e, port 1, port 2, port 0 (31 bits)
    localparam integer SW = 31;
    wire [SW-1:0] pins_raw;
    reg [SW-1:0] sync1_reg;
    reg [SW-1:0] sync2_reg;
    reg strobe_d_reg;

    reg [7:0] code_mem [0:`EPL_CODE_DEPTH-1];
    reg [7:0] enc_mem [0:`EPL_ENC_DEPTH-1];
    reg [`EPL_ENC_DEPTH-1:0] enc_written_reg;
    reg [2:0] lock_reg;
    reg acc_latched_reg;
    reg [2:0] mode_reg;
    reg [7:0] p0_out_reg;
    reg p0_oe_reg;

    reg [1:0] ctrl_reg;
    reg [`EPL_CODE_AW-1:0] addr_reg;
    reg [31:0] hrdata_reg;
    reg wr_pend_reg;
    reg [11:0] wr_off_reg;

    wire rst_s;
    wire program_store_strobe_n_s;
    wire strobe_s;
    wire acc_pin_s;
    wire volt_s;
    wire [4:0] sel_s;
    wire [`EPL_CODE_AW-1:0] pin_addr;
    wire [7:0] pin_data;
    wire strobe_fall;
    wire [`EPL_ENC_AW-1:0] enc_idx;
    wire [7:0] enc_byte;
    wire [7:0] code_byte;
    wire [7:0] verify_byte;
    wire [7:0] sig_byte;
    wire prog_block;
    wire verify_block;
    wire ext_read_block;
    reg [2:0] mode_next;
    reg [1:0] level;
    wire [7:0] core_byte;
    wire [7:0] core_enc;
    wire [7:0] core_code;
    wire addr_ok;
    wire [11:0] off;

    assign pins_raw = {reset_pin, program_store_strobe_n,
        latch_or_prog_strobe, ext_access_or_prog_voltage,
        prog_voltage_present,
        select_a, select_b, select_c, select_d, select_e,
        port1_in, port2_in, port0_in};

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= {SW{1'b0}};
            sync2_reg <= {SW{1'b0}};
            // match the cleared synchroniser so no false pulse follows reset
            strobe_d_reg <= 1'b0;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            strobe_d_reg <= strobe_s;
        end
    end

    assign rst_s = sync2_reg[30];
    assign program_store_strobe_n_s = sync2_reg[29];
    assign strobe_s = sync2_reg[28];
    assign acc_pin_s = sync2_reg[27];
    assign volt_s = sync2_reg[26];
    assign sel_s = sync2_reg[25:21];
    // address A0-A7 on port 1, A8-A12 on port 2
    assign pin_addr = {sync2_reg[12:8], sync2_reg[20:13]};
    assign pin_data = sync2_reg[7:0];
    // program pulse is active low; act on its leading edge
    assign strobe_fall = strobe_d_reg & ~strobe_s;

    // cumulative lock bits with highest set bit winning
    always @* begin
        if (lock_reg[2]) begin
            level = 2'd3;
        end else if (lock_reg[1]) begin
            level = 2'd2;
        end else if (lock_reg[0]) begin
            level = 2'd1;
        end else begin
            level = 2'd0;
        end
    end

    assign prog_block = (level != 2'd0);
    assign verify_block = (level >= 2'd2);
    assign ext_read_block = (level != 2'd0);
    assign ext_exec_enable = (level != 2'd3);
    assign security_level = level;

    // mode decode from the set-up levels
    always @* begin
        mode_next = `EPL_MODE_IDLE;
        if (rst_s && !program_store_strobe_n_s) begin
            if (volt_s) begin
                case (sel_s)
                    `EPL_SEL_PROG_CODE: begin
                        mode_next = `EPL_MODE_PCODE;
                    end
                    `EPL_SEL_PROG_ENC: begin
                        mode_next = `EPL_MODE_PENC;
                    end
                    `EPL_SEL_LOCK1, `EPL_SEL_LOCK2, `EPL_SEL_LOCK3: begin
                        mode_next = `EPL_MODE_PLOCK;
                    end
                    default: begin
                        mode_next = `EPL_MODE_IDLE;
                    end
                endcase
            end else if (strobe_s && acc_pin_s) begin
                // select b is a don't care in both read modes
                if ((sel_s & `EPL_SEL_VER_MASK) == `EPL_SEL_VERIFY) begin
                    mode_next = `EPL_MODE_VERIFY;
                end else if ((sel_s & `EPL_SEL_VER_MASK) ==
                        `EPL_SEL_SIGN) begin
                    mode_next = `EPL_MODE_SIGN;
                end
            end
        end
    end

    assign enc_idx = pin_addr[`EPL_ENC_AW-1:0];
    assign enc_byte = enc_written_reg[enc_idx] ? enc_mem[enc_idx]
        : `EPL_ERASED;
    assign code_byte = code_mem[pin_addr];
    // xnor: erased key passes code through, erased code shows the key
    assign verify_byte = ~(code_byte ^ enc_byte);
    assign sig_byte = SIG_WORD[{pin_addr[1:0], 3'b000} +: 8];

    // arrays are not reset: they model nonvolatile cells
    always @(posedge clock) begin
        if (strobe_fall && !prog_block) begin
            if (mode_reg == `EPL_MODE_PCODE) begin
                code_mem[pin_addr] <= pin_data;
            end
            if (mode_reg == `EPL_MODE_PENC) begin
                enc_mem[enc_idx] <= pin_data;
            end
        end
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= `EPL_MODE_IDLE;
            enc_written_reg <= {`EPL_ENC_DEPTH{1'b0}};
            lock_reg <= 3'b000;
            p0_out_reg <= 8'h00;
            p0_oe_reg <= 1'b0;
            acc_latched_reg <= 1'b1;
        end else begin
            mode_reg <= mode_next;
            if (strobe_fall && !prog_block &&
                    mode_reg == `EPL_MODE_PENC) begin
                enc_written_reg[enc_idx] <= 1'b1;
            end
            // lock bits remain programmable at any level
            if (strobe_fall && mode_reg == `EPL_MODE_PLOCK) begin
                case (sel_s)
                    `EPL_SEL_LOCK1: lock_reg[0] <= 1'b1;
                    `EPL_SEL_LOCK2: lock_reg[1] <= 1'b1;
                    `EPL_SEL_LOCK3: lock_reg[2] <= 1'b1;
                    default: lock_reg <= lock_reg;
                endcase
            end
            if (mode_reg == `EPL_MODE_VERIFY && !verify_block) begin
                p0_out_reg <= verify_byte;
                p0_oe_reg <= 1'b1;
            end else if (mode_reg == `EPL_MODE_SIGN) begin
                p0_out_reg <= sig_byte;
                p0_oe_reg <= 1'b1;
            end else begin
                p0_out_reg <= 8'h00;
                p0_oe_reg <= 1'b0;
            end
            // access pin caught while reset is held
            if (rst_s) begin
                acc_latched_reg <= acc_pin_s;
            end
        end
    end

    assign port0_out = p0_out_reg;
    assign port0_oe = p0_oe_reg;
    // locked parts use the value caught at reset, otherwise the live pin
    // both branches carry the pin level, which is already active low
    assign ext_access_effective_n = prog_block ? acc_latched_reg
        : acc_pin_s;

    // software code read through the bus, as from internal or external fetch
    assign core_code = code_mem[addr_reg];
    assign core_enc = core_code;
    assign core_byte = (ctrl_reg[`EPL_CTRL_EXT] && ext_read_block) ?
        `EPL_ERASED : core_enc;

    // ahb-lite slave with zero wait states
    assign off = haddr[11:0];
    assign addr_ok = hsel && hready && (htrans == `EPL_HTRANS_NONSEQ);

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= `EPL_CTRL_RESET;
            addr_reg <= {`EPL_CODE_AW{1'b0}};
            hrdata_reg <= 32'h0000_0000;
            wr_pend_reg <= 1'b0;
            wr_off_reg <= 12'h000;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_off_reg <= off;
            end
            if (wr_pend_reg) begin
                case (wr_off_reg)
                    `EPL_OFF_CTRL: ctrl_reg <= hwdata[1:0];
                    `EPL_OFF_ADDR: addr_reg <= hwdata[`EPL_CODE_AW-1:0];
                    default: ctrl_reg <= ctrl_reg;
                endcase
            end
            if (addr_ok && !hwrite) begin
                case (off)
                    `EPL_OFF_CTRL: hrdata_reg <= {30'd0, ctrl_reg};
                    `EPL_OFF_ADDR: hrdata_reg <= {19'd0, addr_reg};
                    `EPL_OFF_DATA: hrdata_reg <= {24'd0, core_byte};
                    `EPL_OFF_STAT: hrdata_reg <= {22'd0, acc_latched_reg,
                        ext_exec_enable, mode_reg, lock_reg, level};
                    default: hrdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = `EPL_HRESP_OKAY;
endmodule
`default_nettype wire

// ---- test/epl_checker_assertions.sv ----
// assertions on the pins and bus of the program memory block
`timescale 1ns/1ps
`default_nettype none
module epl_checker (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic reset_pin,
    input wire logic latch_or_prog_strobe,
    input wire logic prog_voltage_present,
    input wire logic select_d,
    input wire logic select_e,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic port0_oe,
    input wire logic ext_exec_enable,
    input wire logic [1:0] security_level,
    input wire logic [31:0] hrdata
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    wire rd_c = hsel && htrans == 2'b10 && !hwrite;
    verify_off_a:
        assert property ((security_level >= 2'd2 && select_d && select_e)[*6]
            |-> !port0_oe) else $error("verify output driven while locked");
    ext_exec_a:
        assert property (ext_exec_enable == (security_level != 2'd3))
            else $error("external execution enable wrong");
    reset_quiet_a:
        assert property ((!reset_pin)[*5] |-> !port0_oe)
            else $error("data lines driven outside set-up");
    strobe_quiet_a:
        assert property ((!latch_or_prog_strobe)[*6] |-> !port0_oe)
            else $error("data lines driven during a program pulse");
    vpp_quiet_a:
        assert property (prog_voltage_present[*6] |-> !port0_oe)
            else $error("data lines driven in a program mode");
    level_hold_a:
        assert property (security_level >= $past(security_level))
            else $error("security level dropped");
    unmapped_zero_a:
        assert property (rd_c && haddr == 32'h0000_0010 |=> hrdata == 32'h0)
            else $error("unmapped read not zero");
    stat_level_a:
        assert property (rd_c && haddr == 32'h0000_000c
            |=> hrdata[1:0] == $past(security_level)) else $error("bad level");
endmodule
bind epl_core epl_checker chk_u (.*);
`default_nettype wire

// ---- test/epl_prog_model.sv ----
// external programmer model driving mode, address and data pins
`timescale 1ns/1ps
`default_nettype none
module epl_prog_model (
    input wire logic clock,
    input wire logic [7:0] p0_wire,
    output logic rst_o,
    output logic strobe_o,
    output logic vpp_o,
    output logic [4:0] sel_o,
    output logic [12:0] addr_o,
    output logic [7:0] d_o,
    output logic d_oe
);
    initial begin
        rst_o = 1'b0;
        strobe_o = 1'b1;
        vpp_o = 1'b0;
        sel_o = 5'h00;
        addr_o = 13'h0000;
        d_o = 8'h00;
        d_oe = 1'b0;
    end
    // levels settle well before the pulse since the pins pass a synchroniser
    task automatic op(input logic [4:0] sel, input logic [12:0] a,
            input logic [7:0] d, input logic prog, output logic [7:0] q);
        begin
            rst_o <= 1'b1;
            sel_o <= sel;
            addr_o <= a;
            d_o <= d;
            d_oe <= prog;
            vpp_o <= prog;
            repeat (6) @(posedge clock);
            strobe_o <= ~prog;
            repeat (6) @(posedge clock);
            strobe_o <= 1'b1;
            repeat (6) @(posedge clock);
            q = p0_wire;
            rst_o <= 1'b0;
            d_oe <= 1'b0;
            repeat (6) @(posedge clock);
        end
    endtask
endmodule
`default_nettype wire

// ---- test/eprom_program_verify_lock_tb.sv ----
// self-checking bench for the program memory access and lock block
`timescale 1ns/1ps
`default_nettype none
module eprom_program_verify_lock_tb;
    localparam [31:0] SIG = 32'h3c96_1e87; // arbitrary value
    logic clock, arst_n, hsel, hwrite, hreadyout, hresp, p0_oe, ext_en;
    logic rst, strobe, vpp, d_oe, acc, eff_n;
    logic [1:0] htrans, level;
    logic [4:0] sel;
    logic [7:0] d, pd, p0_out, p0_wire, q;
    logic [12:0] a, pa;
    logic [31:0] haddr, hwdata, hrdata, rd, rng;
    logic [7:0] code_m [int];
    logic [7:0] enc_m [64];
    integer n_fail, comparisons, i;
    // released data lines float up to the external pull-ups
    assign p0_wire = p0_oe ? p0_out : (d_oe ? pd : 8'hff);
    epl_prog_model prog_u (.clock(clock), .p0_wire(p0_wire), .rst_o(rst),
        .strobe_o(strobe), .vpp_o(vpp), .sel_o(sel), .addr_o(pa), .d_o(pd),
        .d_oe(d_oe));
    epl_core #(.SIG_WORD(SIG)) dut_u (.clock(clock), .arst_n(arst_n),
        .reset_pin(rst), .program_store_strobe_n(1'b0),
        .latch_or_prog_strobe(strobe), .ext_access_or_prog_voltage(acc),
        .prog_voltage_present(vpp), .external_access_n(1'b0),
        .select_a(sel[4]), .select_b(sel[3]), .select_c(sel[2]),
        .select_d(sel[1]), .select_e(sel[0]), .port1_in(pa[7:0]),
        .port2_in(pa[12:8]), .port0_in(p0_wire), .port0_out(p0_out),
        .port0_oe(p0_oe), .ext_exec_enable(ext_en),
        .ext_access_effective_n(eff_n), .security_level(level), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value at %0t: %h expected %h", $time,
                    seen, exp);
            end
        end
    endtask
    function automatic logic [31:0] step(input logic [31:0] s);
        logic [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            step = t ^ (t << 5);
        end
    endfunction
    // access pin low for a while: unlocked follows it, locked keeps latch
    task automatic acc_check(input logic [31:0] exp);
        begin
            acc <= 1'b0;
            repeat (4) @(posedge clock);
            check({31'h0, eff_n}, exp);
            acc <= 1'b1;
            repeat (4) @(posedge clock);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] ad,
            input logic [31:0] wd);
        begin
            hsel <= 1'b1;
            haddr <= ad;
            hwrite <= w;
            htrans <= 2'b10;
            do @(posedge clock); while (hreadyout !== 1'b1);
            htrans <= 2'b00;
            hwdata <= wd;
            do @(posedge clock); while (hreadyout !== 1'b1);
            rd = hrdata;
            check({31'h0, hresp}, 32'h0);
        end
    endtask
    task automatic ver(input logic [12:0] ad);
        logic [7:0] e;
        begin
            prog_u.op(5'b00011, ad, 8'h00, 1'b0, q);
            e = ~(code_m[ad] ^ enc_m[ad[5:0]]);
            check({24'h0, q}, {24'h0, e});
        end
    endtask
    task automatic print_verdict();
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        #400000;
        n_fail = n_fail + 1;
        print_verdict();
    end
    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        acc = 1'b1;
        n_fail = 0;
        comparisons = 0;
        rng = 32'hefcd;
        for (i = 0; i < 64; i++)
            enc_m[i] = 8'hff;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        ahb(1'b0, 32'h0000_0000, 32'h0);
        check(rd, 32'h0000_0002);
        ahb(1'b0, 32'h0000_0010, 32'h0);
        check(rd, 32'h0000_0000);
        acc_check(32'h0);
        for (i = 0; i < 8; i++) begin
            rng = step(rng);
            a = (i == 0) ? 13'h0005 : (i == 1) ? 13'h1fc5 : rng[12:0];
            d = (i == 1) ? 8'hff : rng[20:13];
            code_m[a] = d;
            prog_u.op(5'b01111, a, d, 1'b1, q);
        end
        foreach (code_m[k])
            ver(k[12:0]);
        rng = step(rng);
        enc_m[5] = rng[7:0];
        prog_u.op(5'b01101, 13'h0005, rng[7:0], 1'b1, q);
        foreach (code_m[k])
            ver(k[12:0]);
        for (i = 0; i < 4; i++) begin
            prog_u.op(5'b00000, 13'(i), 8'h00, 1'b0, q);
            check({24'h0, q}, {24'h0, SIG[8*i +: 8]});
        end
        ahb(1'b1, 32'h0000_0004, 32'h0000_0005);
        ahb(1'b0, 32'h0000_0008, 32'h0);
        check(rd, {24'h0, code_m[5]});
        prog_u.op(5'b11111, 13'h0000, 8'h00, 1'b1, q);
        check({30'h0, level}, 32'h1);
        acc_check(32'h1);
        prog_u.op(5'b01111, 13'h0005, ~code_m[5], 1'b1, q);
        ver(13'h0005);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
        ahb(1'b0, 32'h0000_0008, 32'h0);
        check(rd, 32'h0000_00ff);
        ahb(1'b0, 32'h0000_000c, 32'h0);
        check({30'h0, rd[1:0]}, 32'h1);
        prog_u.op(5'b11100, 13'h0000, 8'h00, 1'b1, q);
        prog_u.op(5'b00011, 13'h0005, 8'h00, 1'b0, q);
        check({24'h0, q}, 32'h0000_00ff);
        prog_u.op(5'b10110, 13'h0000, 8'h00, 1'b1, q);
        check({30'h0, level}, 32'h3);
        check({31'h0, ext_en}, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
